// File: common/pwc_pkg.sv
// constants, types and register map of the power stage waveform controller
package pwc_pkg;
  // register byte offsets on the ahb-lite bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SA = 8'h04;
  localparam logic [7:0] OFS_RA = 8'h08;
  localparam logic [7:0] OFS_SB = 8'h0c;
  localparam logic [7:0] OFS_RB = 8'h10;
  localparam logic [7:0] OFS_MATRIX = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_IEN = 8'h1c;
  localparam logic [7:0] OFS_CAPT = 8'h20;
  localparam logic [7:0] OFS_COUNT = 8'h24;
  // control register fields
  localparam int CTL_RUN = 0;
  localparam int CTL_MODE = 1;
  localparam int CTL_PLL = 3;
  localparam int CTL_POL_A = 4;
  localparam int CTL_POL_B = 5;
  localparam int CTL_LOCK = 6;
  localparam int CTL_AUTO = 7;
  localparam int CTL_FLT0 = 8;
  localparam int CTL_FLT1 = 9;
  localparam int CTL_SEL3 = 10;
  localparam int CTL_SEL4 = 11;
  localparam int CTL_MTX = 12;
  localparam int CTL_SYEN = 13;
  localparam int CTL_W = 14;
  // status flag positions
  localparam int ST_OVF = 0;
  localparam int ST_FLT = 1;
  localparam int ST_CAP = 2;
  // field layout of the deassert compare of half b
  localparam int FRAC_LSB = 12;
  localparam int CMP_W = 12;
  localparam int FRAC_W = 4;
  // reset values
  localparam logic [CTL_W-1:0] CTRL_RST = 14'h0000;
  localparam logic [CMP_W-1:0] CMP_RST = 12'h000;
  localparam logic [3:0] MATRIX_RST = 4'h0;
  localparam logic [2:0] IEN_RST = 3'h0;
  // running modes, gray coded
  typedef enum logic [1:0] {
    MODE_FOUR = 2'b00,
    MODE_TWO = 2'b01,
    MODE_ONE = 2'b11,
    MODE_CENTRE = 2'b10
  } pwc_mode_e;
  // one full set of compare values
  typedef struct packed {
    logic [CMP_W-1:0] sa;
    logic [CMP_W-1:0] ra;
    logic [CMP_W-1:0] sb;
    logic [CMP_W-1:0] rb;
    logic [FRAC_W-1:0] frac;
  } pwc_cmp_s;
endpackage : pwc_pkg

// File: dv/pwc_neighbour_model.sv
// adjacent controller instance seen over the sync and halt links
`timescale 1ns/100ps
`default_nettype none
module pwc_neighbour_model (
  // clock
  input wire logic i_mclk,
  // bench commands
  input wire logic i_sync_cmd,
  input wire logic i_halt_cmd,
  // cycle ends reported by the block
  input wire logic i_peer_sync,
  // links into the block, and the cycle-end count for the bench
  output logic o_sync,
  output logic o_halt,
  output int o_peer_cnt
);
  logic [1:0] phase_q = 2'h0;
  logic sync_q = 1'b0;
  logic halt_q = 1'b0;
  int seen_q = 0;
  // our own four-tick cycle; the block must follow it
  always_ff @(posedge i_mclk) begin
    phase_q <= phase_q + 2'h1;
    sync_q <= i_sync_cmd & phase_q[1];
  end
  // halt level held while asked, released low
  always_ff @(posedge i_mclk) begin
    halt_q <= i_halt_cmd;
  end
  // a chained neighbour counts every cycle end it is told of
  always_ff @(posedge i_mclk) begin
    if (i_peer_sync === 1'b1) seen_q <= seen_q + 1;
  end
  assign o_sync = sync_q;
  assign o_halt = halt_q;
  assign o_peer_cnt = seen_q;
endmodule : pwc_neighbour_model
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench of the power stage waveform controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd, c0;
  logic hready, hresp, a_out, b_out, three, four, irq, adc, sync_out, halt_out;
  logic pll = 1'b0, pll_run = 1'b0, pin = 1'b0, comp = 1'b0, emg = 1'b0;
  logic sync_cmd = 1'b0, halt_cmd = 1'b0, nb_sync, nb_halt;
  logic [2:0] pll_div = 3'h0;
  logic [5:0] obs;
  int peer, errors = 0, checks = 0;
  int cnt [7];
  localparam logic [31:0] RUN1 = {29'h0, pwc_pkg::MODE_ONE, 1'b1};

  // 200 mhz main clock
  always #2.5 clk = ~clk;
  // slow pll ticks, one rising edge in eight cycles, only when enabled
  always @(posedge clk) begin
    pll_div <= pll_div + 3'h1;
    pll <= pll_run & pll_div[2];
  end
  assign obs = {adc, sync_out, four, three, b_out, a_out};

  pwc_top uut (.I_MCLK(clk), .I_SYS_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .I_PLL_CLK(pll), .I_RETRIGGER_FAULT_PIN(pin), .I_COMPARATOR_IN(comp),
    .I_EMERGENCY(emg), .I_NEIGHBOUR_SYNC_IN(nb_sync), .I_HALT_REQUEST_IN(nb_halt),
    .O_HALF_A_OUTPUT(a_out), .O_HALF_B_OUTPUT(b_out), .O_DUP_OUTPUT_THREE(three),
    .O_DUP_OUTPUT_FOUR(four), .O_WAVEFORM_IRQ(irq), .O_ADC_SYNC_PULSE(adc),
    .O_NEIGHBOUR_SYNC_OUT(sync_out), .O_HALT_REQUEST_OUT(halt_out));

  pwc_neighbour_model nbr (.i_mclk(clk), .i_sync_cmd(sync_cmd), .i_halt_cmd(halt_cmd),
    .i_peer_sync(sync_out), .o_sync(nb_sync), .o_halt(nb_halt), .o_peer_cnt(peer));

  function automatic logic [31:0] bv(input int p);
    return 32'h1 << p;
  endfunction : bv

  task automatic wrap_up;
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %0h want %0h", $time, m, got, exp);
    end
  endtask : chk

  // one single ahb-lite transfer; waits on hready, never on a fixed count
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    rd = hrdata;
    // writes answer at once, reads add exactly one wait state
    chk(n, {31'h0, ~wr}, "wait states");
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask : rdc

  // settle, then count high cycles over 60 cycles, a multiple of every period meas_chk judges
  task automatic measure;
    int p0;
    for (int i = 0; i < 7; i++) cnt[i] = 0;
    repeat (12) @(posedge clk);
    p0 = peer;
    repeat (60) begin
      @(posedge clk);
      for (int j = 0; j < 6; j++) cnt[j] += int'(obs[j] === 1'b1);
    end
    cnt[6] = peer - p0;
  endtask : measure

  // negative expectation means that count is not judged here
  task automatic meas_chk(input int e [7], input string m);
    measure;
    for (int i = 0; i < 7; i++) begin
      if (e[i] >= 0) chk(cnt[i], e[i], m);
    end
  endtask : meas_chk

  // hang guard, well past the roughly 1400 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    wrap_up;
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({a_out, b_out, three, four, irq, adc, sync_out, halt_out, hresp}, 0, "idle");
    rdc(pwc_pkg::OFS_COUNT, 32'h0, "count reset");
    rdc(pwc_pkg::OFS_CTRL, 32'h0, "ctrl reset");
    rdc(8'h3c, 32'h0, "unmapped read");
    wr(pwc_pkg::OFS_SA, 32'hffff_f001);
    rdc(pwc_pkg::OFS_SA, 32'h1, "sa width");
    wr(pwc_pkg::OFS_SB, 32'hffff_f002);
    rdc(pwc_pkg::OFS_SB, 32'h2, "sb width");
    wr(pwc_pkg::OFS_RB, 32'hffff_a005);
    rdc(pwc_pkg::OFS_RB, 32'ha005, "rb fraction");
    wr(pwc_pkg::OFS_RB, 32'h5);
    wr(pwc_pkg::OFS_RA, 32'h3);
    // one ramp: a active on counts 1..2, b on 2..4, period 6
    wr(pwc_pkg::OFS_CTRL, RUN1);
    meas_chk('{20, 30, 20, 20, 10, 10, 10}, "one ramp");
    wr(pwc_pkg::OFS_CTRL, RUN1 | bv(pwc_pkg::CTL_POL_A));
    meas_chk('{40, 30, -1, -1, 10, 10, -1}, "polarity");
    wr(pwc_pkg::OFS_CTRL, RUN1 | bv(pwc_pkg::CTL_SEL3) | bv(pwc_pkg::CTL_SEL4));
    meas_chk('{20, 30, 30, 30, -1, -1, -1}, "selectors");
    wr(pwc_pkg::OFS_MATRIX, 32'h5);
    wr(pwc_pkg::OFS_CTRL, RUN1 | bv(pwc_pkg::CTL_MTX));
    meas_chk('{60, 0, -1, -1, 10, -1, -1}, "matrix");
    // lock holds a new set; auto hold with rb written last overrides it
    wr(pwc_pkg::OFS_CTRL, RUN1 | bv(pwc_pkg::CTL_LOCK));
    wr(pwc_pkg::OFS_SA, 32'h0);
    meas_chk('{20, -1, -1, -1, -1, -1, -1}, "lock");
    wr(pwc_pkg::OFS_CTRL, RUN1 | bv(pwc_pkg::CTL_LOCK) | bv(pwc_pkg::CTL_AUTO));
    wr(pwc_pkg::OFS_SA, 32'h0);
    wr(pwc_pkg::OFS_RB, 32'h5);
    meas_chk('{30, 30, -1, -1, 10, -1, -1}, "auto wins");
    wr(pwc_pkg::OFS_SA, 32'h1);
    // stop once so the new set loads; restarts every 4 would block cycle ends
    wr(pwc_pkg::OFS_CTRL, 32'h0);
    wr(pwc_pkg::OFS_CTRL, RUN1 | bv(pwc_pkg::CTL_SYEN));
    sync_cmd <= 1'b1;
    meas_chk('{30, -1, -1, -1, -1, -1, -1}, "sync restart");
    sync_cmd <= 1'b0;
    halt_cmd <= 1'b1;
    meas_chk('{0, 0, 0, 0, -1, -1, -1}, "halt in");
    bus(1'b0, pwc_pkg::OFS_COUNT, 32'h0);
    c0 = rd;
    rdc(pwc_pkg::OFS_COUNT, c0, "count frozen");
    halt_cmd <= 1'b0;
    wr(pwc_pkg::OFS_CTRL, RUN1 | bv(pwc_pkg::CTL_POL_A) | bv(pwc_pkg::CTL_POL_B));
    emg <= 1'b1;
    meas_chk('{0, 0, 0, 0, -1, -1, -1}, "emergency");
    chk(halt_out, 1'b1, "halt out on emergency");
    emg <= 1'b0;
    wr(pwc_pkg::OFS_CTRL, RUN1);
    wr(pwc_pkg::OFS_IEN, bv(pwc_pkg::ST_CAP));
    pin <= 1'b1;
    repeat (8) @(posedge clk);
    pin <= 1'b0;
    bus(1'b0, pwc_pkg::OFS_CAPT, 32'h0);
    chk(rd <= 32'h5, 1'b1, "capture value");
    chk(irq, 1'b1, "capture irq");
    wr(pwc_pkg::OFS_STATUS, bv(pwc_pkg::ST_CAP));
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "irq cleared");
    wr(pwc_pkg::OFS_IEN, bv(pwc_pkg::ST_OVF));
    repeat (8) @(posedge clk);
    chk(irq, 1'b1, "overflow irq");
    wr(pwc_pkg::OFS_IEN, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(pwc_pkg::OFS_STATUS, 32'h7);
      wr(pwc_pkg::OFS_CTRL, RUN1 | bv(pwc_pkg::CTL_FLT0 + k));
      pin <= (k == 0);
      comp <= (k == 1);
      meas_chk('{0, 0, -1, -1, -1, -1, -1}, "fault halts");
      chk(halt_out, 1'b1, "halt out on fault");
      bus(1'b0, pwc_pkg::OFS_STATUS, 32'h0);
      chk(rd[pwc_pkg::ST_FLT], 1'b1, "fault flag");
      pin <= 1'b0;
      comp <= 1'b0;
    end
    wr(pwc_pkg::OFS_CTRL, RUN1 | bv(pwc_pkg::CTL_PLL));
    bus(1'b0, pwc_pkg::OFS_COUNT, 32'h0);
    c0 = rd;
    repeat (30) @(posedge clk);
    rdc(pwc_pkg::OFS_COUNT, c0, "no pll tick");
    pll_run <= 1'b1;
    repeat (40) @(posedge clk);
    bus(1'b0, pwc_pkg::OFS_COUNT, 32'h0);
    chk(rd != c0, 1'b1, "pll ticks");
    pll_run <= 1'b0;
    // every running mode must keep cycling
    for (int m = 0; m < 4; m++) begin
      wr(pwc_pkg::OFS_CTRL, 32'h1 | (m << pwc_pkg::CTL_MODE));
      measure;
      chk(cnt[4] > 0 && cnt[0] > 0, 1'b1, "mode runs");
    end
    // fraction 15 stretches 15 of 16 cycles to 7 counts: 8 or 9 adc pulses in 60
    wr(pwc_pkg::OFS_RB, 32'hf005);
    measure;
    chk(cnt[5] == 8 || cnt[5] == 9, 1'b1, "fraction stretch");
    wrap_up;
  end
endmodule : tb_top
`default_nettype wire

// File: verilog/pwc_top.sv
// power stage waveform controller with ahb-lite register slave
// What this block does
// - one counter counts up, or up and down when centre-aligned, between register limits per running mode
// - half a alone generates the first waveform output
// - half b alone generates the second output from its own compares
// - each of the two inputs has its own input module, and both act on the shared counter
// - two selectors let outputs three and four copy output a or b
// - a 2x2 matrix drives programmed levels per waveform sub-cycle
// - software selects active high or active low per half; outputs three and four follow the half they copy
// - half a uses 12-bit assert and deassert compares against the counter
// - half b uses 12-bit assert and deassert compares in bits 11:0
// - bits 15:12 of half b deassert hold the cycle length fraction
// - a retrigger copies the counter into a readable 12-bit capture value
// - one interrupt line combines overflow, fault and capture sources
// - pin input and comparator input each act as retrigger or fault
// - counting runs from the i/o clock or from the pll clock input
// - neighbour sync input restarts the cycle, sync output marks cycle end
// - halt request input stops counting, halt request output tells neighbours
// - an adc sync pulse marks each count at which the counter equals the half a deassert compare
// - emergency input forces every waveform output low in hardware
// - four running modes: four-ramp, two-ramp, one-ramp, centre-aligned
// - with both locks set, the automatic update hold wins
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module pwc_top (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  // ahb-lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // asynchronous inputs
  input wire logic I_PLL_CLK,
  input wire logic I_RETRIGGER_FAULT_PIN,
  input wire logic I_COMPARATOR_IN,
  input wire logic I_EMERGENCY,
  input wire logic I_NEIGHBOUR_SYNC_IN,
  input wire logic I_HALT_REQUEST_IN,
  // waveform outputs
  output logic O_HALF_A_OUTPUT,
  output logic O_HALF_B_OUTPUT,
  output logic O_DUP_OUTPUT_THREE,
  output logic O_DUP_OUTPUT_FOUR,
  // system signals
  output logic O_WAVEFORM_IRQ,
  output logic O_ADC_SYNC_PULSE,
  output logic O_NEIGHBOUR_SYNC_OUT,
  output logic O_HALT_REQUEST_OUT
);
  logic [pwc_pkg::CTL_W-1:0] ctrl_q;
  pwc_pkg::pwc_cmp_s sh_q;
  pwc_pkg::pwc_cmp_s act_q;
  logic [3:0] mtx_q;
  logic [2:0] ien_q;
  logic [2:0] flag_q;
  logic [11:0] cap_q;
  logic [11:0] cnt_q;
  logic [1:0] ramp_q;
  logic up_q;
  logic [3:0] acc_q;
  logic stretch_q;
  logic rb_wr_q;
  logic wr_q;
  logic rd_q;
  logic [7:0] addr_q;
  // synchroniser stages: pll, two inputs, emergency, sync, halt
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [5:0] s3_q;
  logic tick;
  logic run_eff;
  logic restart;
  logic cyc_end;
  logic [1:0] last_ramp;
  logic [11:0] lim;
  logic lvl_a;
  logic lvl_b;
  logic sub_b;
  logic pa;
  logic pb;
  logic [2:0] flag_clr;
  logic [2:0] flag_set;
  logic [1:0] retrig;
  logic [1:0] fault_lvl;
  logic [1:0] fault_edge;
  logic do_update;
  logic [31:0] rd_mux;
  pwc_pkg::pwc_mode_e mode;

  assign mode = pwc_pkg::pwc_mode_e'(ctrl_q[pwc_pkg::CTL_MODE+:2]);

  // two flip-flops before any logic, third stage only for edge detection
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      s1_q <= 6'h00;
      s2_q <= 6'h00;
      s3_q <= 6'h00;
    end else begin
      s1_q <= {I_HALT_REQUEST_IN, I_NEIGHBOUR_SYNC_IN, I_EMERGENCY,
               I_COMPARATOR_IN, I_RETRIGGER_FAULT_PIN, I_PLL_CLK};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // counting tick from i/o clock or pll clock rising edges
  assign tick = ctrl_q[pwc_pkg::CTL_PLL] ? (s2_q[0] & ~s3_q[0]) : 1'b1;

  // per-input modules: pin is input 0, comparator is input 1, both act on the shared counter
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_in
      logic fen;
      assign fen = ctrl_q[pwc_pkg::CTL_FLT0+gi];
      assign retrig[gi] = s2_q[gi+1] & ~s3_q[gi+1] & ~fen;
      assign fault_lvl[gi] = s2_q[gi+1] & fen;
      assign fault_edge[gi] = s2_q[gi+1] & ~s3_q[gi+1] & fen;
    end
  endgenerate

  // halt from a neighbour or an active fault stops the counter
  assign run_eff = ctrl_q[pwc_pkg::CTL_RUN] & ~s2_q[5] & ~(|fault_lvl);
  assign restart = ctrl_q[pwc_pkg::CTL_RUN] & ((|retrig) |
                   (ctrl_q[pwc_pkg::CTL_SYEN] & s2_q[4] & ~s3_q[4]));

  // ramp limits per mode, fraction stretches the last ramp by one count
  always_comb begin
    last_ramp = 2'd0;
    lim = act_q.rb;
    unique case (mode)
      pwc_pkg::MODE_FOUR: begin
        last_ramp = 2'd3;
        unique case (ramp_q)
          2'd0: lim = act_q.sa + 12'd1;
          2'd1: lim = act_q.ra;
          2'd2: lim = act_q.sb + 12'd1;
          2'd3: lim = act_q.rb;
        endcase
      end
      pwc_pkg::MODE_TWO: begin
        last_ramp = 2'd1;
        lim = ramp_q[0] ? act_q.rb : act_q.ra;
      end
      pwc_pkg::MODE_ONE: begin
        last_ramp = 2'd0;
        lim = act_q.rb;
      end
      pwc_pkg::MODE_CENTRE: begin
        last_ramp = 2'd0;
        lim = act_q.rb;
      end
    endcase
    if (ramp_q == last_ramp && stretch_q) begin
      lim = lim + 12'd1;
    end
  end

  assign cyc_end = run_eff & tick & ((mode == pwc_pkg::MODE_CENTRE) ?
                   (~up_q & cnt_q == 12'd0) : (cnt_q >= lim & ramp_q == last_ramp));

  // the waveform counter
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      cnt_q <= 12'h000;
      ramp_q <= 2'd0;
      up_q <= 1'b1;
    end else if (restart) begin
      cnt_q <= 12'h000;
      ramp_q <= 2'd0;
      up_q <= 1'b1;
    end else if (run_eff && tick) begin
      if (mode == pwc_pkg::MODE_CENTRE) begin
        if (up_q) begin
          if (cnt_q >= lim) begin
            up_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q + 12'd1;
          end
        end else if (cnt_q == 12'd0) begin
          up_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 12'd1;
        end
      end else if (cnt_q >= lim) begin
        cnt_q <= 12'h000;
        ramp_q <= (ramp_q == last_ramp) ? 2'd0 : ramp_q + 2'd1;
      end else begin
        cnt_q <= cnt_q + 12'd1;
      end
    end
  end

  // fraction accumulator spreads stretched cycles evenly over 16
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      acc_q <= 4'h0;
      stretch_q <= 1'b0;
    end else if (cyc_end) begin
      {stretch_q, acc_q} <= {1'b0, acc_q} + {1'b0, act_q.frac};
    end
  end

  // compare values reach the counter at cycle end, or at once while run is clear
  always_comb begin
    if (ctrl_q[pwc_pkg::CTL_AUTO]) begin
      do_update = cyc_end & rb_wr_q;
    end else begin
      do_update = cyc_end & ~ctrl_q[pwc_pkg::CTL_LOCK];
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      act_q <= '0;
    end else if (!ctrl_q[pwc_pkg::CTL_RUN] || do_update) begin
      act_q <= sh_q;
    end
  end

  // levels of both halves and the current sub-cycle
  always_comb begin
    lvl_a = 1'b0;
    lvl_b = 1'b0;
    sub_b = 1'b0;
    unique case (mode)
      pwc_pkg::MODE_FOUR: begin
        lvl_a = (ramp_q == 2'd1);
        lvl_b = (ramp_q == 2'd3);
        sub_b = ramp_q[1];
      end
      pwc_pkg::MODE_TWO: begin
        lvl_a = ~ramp_q[0] & cnt_q >= act_q.sa & cnt_q < act_q.ra;
        lvl_b = ramp_q[0] & cnt_q >= act_q.sb & cnt_q < act_q.rb;
        sub_b = ramp_q[0];
      end
      pwc_pkg::MODE_ONE: begin
        lvl_a = cnt_q >= act_q.sa & cnt_q < act_q.ra;
        lvl_b = cnt_q >= act_q.sb & cnt_q < act_q.rb;
        sub_b = cnt_q >= act_q.ra;
      end
      pwc_pkg::MODE_CENTRE: begin
        lvl_a = cnt_q < act_q.sa;
        lvl_b = cnt_q >= act_q.sb;
        sub_b = ~up_q;
      end
    endcase
  end

  // pin levels; faults clear them before polarity, emergency drops them after it, matrix overrides levels
  always_comb begin
    if (ctrl_q[pwc_pkg::CTL_MTX]) begin
      pa = mtx_q[{sub_b, 1'b0}];
      pb = mtx_q[{sub_b, 1'b1}];
    end else begin
      pa = lvl_a;
      pb = lvl_b;
    end
    if (!run_eff) begin
      pa = 1'b0;
      pb = 1'b0;
    end
    pa = pa ^ ctrl_q[pwc_pkg::CTL_POL_A];
    pb = pb ^ ctrl_q[pwc_pkg::CTL_POL_B];
    // emergency applied last so polarity can never lift a pin
    if (s2_q[3]) begin
      pa = 1'b0;
      pb = 1'b0;
    end
  end

  // output pins straight from flops
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_HALF_A_OUTPUT <= 1'b0;
      O_HALF_B_OUTPUT <= 1'b0;
      O_DUP_OUTPUT_THREE <= 1'b0;
      O_DUP_OUTPUT_FOUR <= 1'b0;
    end else begin
      O_HALF_A_OUTPUT <= pa;
      O_HALF_B_OUTPUT <= pb;
      O_DUP_OUTPUT_THREE <= ctrl_q[pwc_pkg::CTL_SEL3] ? pb : pa;
      O_DUP_OUTPUT_FOUR <= ctrl_q[pwc_pkg::CTL_SEL4] ? pb : pa;
    end
  end

  // cycle markers for adc and neighbours, halt request to neighbours
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_ADC_SYNC_PULSE <= 1'b0;
      O_NEIGHBOUR_SYNC_OUT <= 1'b0;
      O_HALT_REQUEST_OUT <= 1'b0;
    end else begin
      O_ADC_SYNC_PULSE <= run_eff & tick & cnt_q == act_q.ra;
      O_NEIGHBOUR_SYNC_OUT <= cyc_end;
      O_HALT_REQUEST_OUT <= |fault_lvl | s2_q[3];
    end
  end

  // capture on retrigger
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      cap_q <= 12'h000;
    end else if (|retrig) begin
      cap_q <= cnt_q;
    end
  end

  // ahb-lite address phase; every read adds one wait state
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end else begin
      O_HRESP <= 1'b0;
      rd_q <= 1'b0;
      O_HREADYOUT <= 1'b1;
      if (I_HREADY) begin
        wr_q <= I_HSEL & I_HTRANS[1] & I_HWRITE;
        rd_q <= I_HSEL & I_HTRANS[1] & ~I_HWRITE;
        O_HREADYOUT <= ~(I_HSEL & I_HTRANS[1] & ~I_HWRITE);
        addr_q <= I_HADDR[7:0];
      end else begin
        wr_q <= 1'b0;
      end
    end
  end

  // read mux, data taken in the wait cycle so it sees earlier writes
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_q)
      pwc_pkg::OFS_CTRL: rd_mux[pwc_pkg::CTL_W-1:0] = ctrl_q;
      pwc_pkg::OFS_SA: rd_mux[11:0] = sh_q.sa;
      pwc_pkg::OFS_RA: rd_mux[11:0] = sh_q.ra;
      pwc_pkg::OFS_SB: rd_mux[11:0] = sh_q.sb;
      pwc_pkg::OFS_RB: rd_mux[15:0] = {sh_q.frac, sh_q.rb};
      pwc_pkg::OFS_MATRIX: rd_mux[3:0] = mtx_q;
      pwc_pkg::OFS_STATUS: rd_mux[2:0] = flag_q;
      pwc_pkg::OFS_IEN: rd_mux[2:0] = ien_q;
      pwc_pkg::OFS_CAPT: rd_mux[11:0] = cap_q;
      pwc_pkg::OFS_COUNT: rd_mux[15:0] = {2'b00, ~up_q, run_eff, cnt_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_HRDATA <= 32'h0000_0000;
    end else if (rd_q) begin
      O_HRDATA <= rd_mux;
    end
  end

  // register writes in the data phase
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      ctrl_q <= pwc_pkg::CTRL_RST;
      sh_q <= '0;
      mtx_q <= pwc_pkg::MATRIX_RST;
      ien_q <= pwc_pkg::IEN_RST;
    end else if (wr_q) begin
      unique case (addr_q)
        pwc_pkg::OFS_CTRL: ctrl_q <= I_HWDATA[pwc_pkg::CTL_W-1:0];
        pwc_pkg::OFS_SA: sh_q.sa <= I_HWDATA[11:0];
        pwc_pkg::OFS_RA: sh_q.ra <= I_HWDATA[11:0];
        pwc_pkg::OFS_SB: sh_q.sb <= I_HWDATA[11:0];
        pwc_pkg::OFS_RB: begin
          sh_q.rb <= I_HWDATA[11:0];
          sh_q.frac <= I_HWDATA[pwc_pkg::FRAC_LSB+:pwc_pkg::FRAC_W];
        end
        pwc_pkg::OFS_MATRIX: mtx_q <= I_HWDATA[3:0];
        pwc_pkg::OFS_IEN: ien_q <= I_HWDATA[2:0];
        default: ;
      endcase
    end
  end

  // automatic hold waits for the half b deassert compare to be written last
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      rb_wr_q <= 1'b0;
    end else if (wr_q && addr_q == pwc_pkg::OFS_RB) begin
      rb_wr_q <= 1'b1;
    end else if (do_update || (wr_q && addr_q != pwc_pkg::OFS_STATUS)) begin
      rb_wr_q <= 1'b0;
    end
  end

  // sticky flags, write one to clear; a new event beats the clear
  always_comb begin
    flag_clr = 3'h0;
    if (wr_q && addr_q == pwc_pkg::OFS_STATUS) begin
      flag_clr = I_HWDATA[2:0];
    end
    flag_set = 3'h0;
    flag_set[pwc_pkg::ST_OVF] = cyc_end;
    flag_set[pwc_pkg::ST_FLT] = |fault_edge;
    flag_set[pwc_pkg::ST_CAP] = |retrig;
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      flag_q <= 3'h0;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_WAVEFORM_IRQ <= 1'b0;
    end else begin
      O_WAVEFORM_IRQ <= |(flag_q & ien_q);
    end
  end

  // checks
  property p_wrap;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      cyc_end && !restart && mode != pwc_pkg::MODE_CENTRE |=> cnt_q == 12'h000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_emerg;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      s2_q[3] |=> !O_HALF_A_OUTPUT && !O_HALF_B_OUTPUT && !O_DUP_OUTPUT_THREE;
  endproperty
  a_emerg: assert property (p_emerg) else $error("emergency left output high");

  property p_cap;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      |retrig |=> cap_q == $past(cnt_q) && flag_q[pwc_pkg::ST_CAP];
  endproperty
  a_cap: assert property (p_cap) else $error("capture missed");

  property p_irq;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      |(flag_q & ien_q) |=> O_WAVEFORM_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_auto;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      ctrl_q[pwc_pkg::CTL_AUTO] && ctrl_q[pwc_pkg::CTL_LOCK] && ctrl_q[pwc_pkg::CTL_RUN]
      && cyc_end && rb_wr_q |=> act_q == $past(sh_q);
  endproperty
  a_auto: assert property (p_auto) else $error("automatic hold ignored");

  property p_dup;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      $stable(ctrl_q) |=> O_DUP_OUTPUT_FOUR ==
      ($past(ctrl_q[pwc_pkg::CTL_SEL4]) ? O_HALF_B_OUTPUT : O_HALF_A_OUTPUT);
  endproperty
  a_dup: assert property (p_dup) else $error("output four mismatch");

  property p_rst;
    @(posedge I_MCLK) I_SYS_RST |=> cnt_q == 12'h000 && !O_HALF_A_OUTPUT;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");

  property p_sync;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      cyc_end |=> O_NEIGHBOUR_SYNC_OUT ##1 !O_NEIGHBOUR_SYNC_OUT || $past(cyc_end, 1);
  endproperty
  a_sync: assert property (p_sync) else $error("sync out missing");

  property p_halt;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      s2_q[5] && !restart |=> $stable(cnt_q);
  endproperty
  a_halt: assert property (p_halt) else $error("counter ran while halted");
endmodule : pwc_top
`default_nettype wire
